// ---- common/lcd_regs.vh ----
`ifndef LCD_REGS_VH
`define LCD_REGS_VH
// ------------------------------------------------------------
// bus register byte offsets
// ------------------------------------------------------------
`define LCD_OFS_CTRL 8'h00
`define LCD_OFS_WREG 8'h04
`define LCD_OFS_STAT 8'h08
`define LCD_OFS_TIMER 8'h0c
`define LCD_OFS_PORT 8'h10
`define LCD_OFS_PINS 8'h14
// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define LCD_CTRL_PS_ASSIGN 0
`define LCD_CTRL_RATE_LO 1
`define LCD_CTRL_RATE_HI 3
`define LCD_CTRL_BANK 4
`define LCD_CTRL_RST 5'h00
// ------------------------------------------------------------
// status fields
// ------------------------------------------------------------
`define LCD_ST_C 0
`define LCD_ST_HALF_CARRY 1
`define LCD_ST_Z 2
`define LCD_ST_POWERDOWN 3
`define LCD_ST_TIMEOUT 4
`define LCD_STAT_RST 5'h18
// ------------------------------------------------------------
// special file addresses (7-bit field)
// ------------------------------------------------------------
`define LCD_F_TIMER 7'h01
`define LCD_F_PROG_LOW 7'h02
`define LCD_F_PORT 7'h05
// ------------------------------------------------------------
// opcode patterns
// ------------------------------------------------------------
`define LCD_OP_STANDBY 14'h0063
`define LCD_OP_RETURN 7'h08
`define LCD_OP_RET_INT 7'h09
`define LCD_OP_MINUS 3'h6
`define LCD_OP_XOR 4'ha
`define LCD_OP_RET_LIT 2'h1
`endif

// ---- core/lcd_core.v ----
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "lcd_regs.vh"
// What this block does
// RULE_01 - word 0x0063 enters standby in one cycle, sets timeout, clears powerdown flag
// RULE_02 - 11 110x k computes literal minus accumulator, updates carry, half carry, zero
// RULE_03 - 11 1010 k computes literal xor accumulator, updates only zero flag
// RULE_04 - reading the I/O port for modify-write uses synchronised pin levels
// RULE_05 - file writes to the timer clear the prescaler when it is assigned there
// RULE_06 - program counter change or true skip costs a second no-operation cycle
// RULE_07 - seven-bit file field selects location 0x00..0x7F within the current bank
// RULE_08 - literal field feeds constant data from the instruction word to the ALU
// RULE_09 - literal subtract and xor results land in accumulator at end of cycle
module lcd_core #(
  parameter MEM_BANKS = 2
) (
  // clock and reset
  input wire clk_sys_i,
  input wire rst_n_i,
  // instruction stream
  input wire instr_valid_i,
  input wire [13:0] instr_i,
  // pins
  input wire [7:0] port_pins_i,
  input wire timer_tick_i,
  output reg [7:0] port_o,
  output reg standby_o,
  output reg pc_change_o,
  output reg nop_cycle_o,
  output reg [7:0] acc_o,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg [7:0] mem_reg [0:MEM_BANKS*128-1];
  reg [4:0] ctrl_reg;
  reg [4:0] stat_reg;
  reg [7:0] timer_reg;
  reg [7:0] ps_reg;
  reg squash_reg;
  reg [7:0] pins_s1_reg;
  reg [7:0] pins_reg;
  reg tick_s1_reg;
  reg tick_s2_reg;
  reg tick_d_reg;
  reg bus_wr_reg;
  reg [7:0] bus_addr_reg;

  function lcd_zero;
    input [7:0] v;
    begin
      lcd_zero = (v == 8'h00);
    end
  endfunction

  // ------------------------------------------------------------
  // decode and execute
  // ------------------------------------------------------------
  wire exec = instr_valid_i & ~squash_reg;
  wire [6:0] fld_f = instr_i[6:0];
  wire [7:0] lit_k = instr_i[7:0];
  wire dsel = instr_i[7];
  wire [2:0] bsel = instr_i[9:7];
  wire bank = (MEM_BANKS > 1) ? ctrl_reg[`LCD_CTRL_BANK] : 1'b0;
  wire [7:0] mem_addr = {bank, fld_f}; // [RULE_07]
  wire [7:0] bmask = 8'h01 << bsel;
  wire [8:0] sub_full = {1'b0, lit_k} - {1'b0, acc_o}; // [RULE_08]
  wire [4:0] sub_low = {1'b0, lit_k[3:0]} - {1'b0, acc_o[3:0]};
  reg [7:0] src;
  reg [7:0] res;
  reg wr_f;
  reg wr_w;
  reg z_we;
  reg cdc_we;
  reg pc_chg;
  reg skip;
  reg sleep_op;

  always @* begin
    // pins, not the latch, so driven-low inputs read back as zero
    if (fld_f == `LCD_F_PORT)
      src = pins_reg; // [RULE_04]
    else if (fld_f == `LCD_F_TIMER)
      src = timer_reg;
    else
      src = mem_reg[mem_addr]; // [RULE_07]
    res = 8'h00;
    wr_f = 1'b0;
    wr_w = 1'b0;
    z_we = 1'b0;
    cdc_we = 1'b0;
    pc_chg = 1'b0;
    skip = 1'b0;
    sleep_op = 1'b0;
    if (exec) begin
      case (instr_i[13:12])
        2'b00: begin
          wr_f = dsel;
          wr_w = ~dsel;
          z_we = 1'b1;
          case (instr_i[11:8])
            4'h0: begin
              z_we = 1'b0;
              wr_w = 1'b0;
              res = acc_o;
              if (instr_i == `LCD_OP_STANDBY)
                sleep_op = 1'b1; // [RULE_01]
              if (~dsel && (fld_f == `LCD_OP_RETURN || fld_f == `LCD_OP_RET_INT))
                pc_chg = 1'b1; // [RULE_06]
            end
            4'h1: res = 8'h00;
            4'h3: res = src - 8'h01;
            4'h4: res = src | acc_o;
            4'h5: res = src & acc_o;
            4'h6: res = src ^ acc_o;
            4'h8: res = src;
            4'h9: res = ~src;
            4'ha: res = src + 8'h01;
            4'hb: begin
              res = src - 8'h01;
              z_we = 1'b0;
              skip = lcd_zero(src - 8'h01); // [RULE_06]
            end
            4'hf: begin
              res = src + 8'h01;
              z_we = 1'b0;
              skip = lcd_zero(src + 8'h01); // [RULE_06]
            end
            default: begin
              // other opcodes are not executed: no file or accumulator write, no flag update
              wr_f = 1'b0;
              wr_w = 1'b0;
              z_we = 1'b0;
            end
          endcase
        end
        2'b01: begin
          case (instr_i[11:10])
            2'b00: begin
              res = src & ~bmask;
              wr_f = 1'b1;
            end
            2'b01: begin
              res = src | bmask;
              wr_f = 1'b1;
            end
            2'b10: skip = ~|(src & bmask); // [RULE_06]
            default: skip = |(src & bmask); // [RULE_06]
          endcase
        end
        2'b10: pc_chg = 1'b1; // [RULE_06]
        default: begin
          if (instr_i[11:9] == `LCD_OP_MINUS) begin
            res = sub_full[7:0]; // [RULE_02]
            wr_w = 1'b1;
            z_we = 1'b1;
            cdc_we = 1'b1;
          end else if (instr_i[11:8] == `LCD_OP_XOR) begin
            res = lit_k ^ acc_o; // [RULE_03]
            wr_w = 1'b1;
            z_we = 1'b1;
          end else if (instr_i[11:10] == `LCD_OP_RET_LIT) begin
            res = lit_k;
            wr_w = 1'b1;
            pc_chg = 1'b1; // [RULE_06]
          end
        end
      endcase
      if (wr_f && fld_f == `LCD_F_PROG_LOW)
        pc_chg = 1'b1; // [RULE_06]
    end
  end

  // ------------------------------------------------------------
  // timer and prescaler
  // ------------------------------------------------------------
  wire tick_rise = tick_s2_reg & ~tick_d_reg;
  wire ps_assign = ctrl_reg[`LCD_CTRL_PS_ASSIGN];
  wire [7:0] ps_top = (8'h02 << ctrl_reg[`LCD_CTRL_RATE_HI:`LCD_CTRL_RATE_LO]) - 8'h01;
  wire tmr_wr = wr_f && fld_f == `LCD_F_TIMER;

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_s1_reg <= 8'h00;
      pins_reg <= 8'h00;
      tick_s1_reg <= 1'b0;
      tick_s2_reg <= 1'b0;
      tick_d_reg <= 1'b0;
      timer_reg <= 8'h00;
      ps_reg <= 8'h00;
    end else begin
      pins_s1_reg <= port_pins_i;
      pins_reg <= pins_s1_reg;
      tick_s1_reg <= timer_tick_i;
      tick_s2_reg <= tick_s1_reg;
      tick_d_reg <= tick_s2_reg;
      if (tmr_wr) begin
        timer_reg <= res;
        if (ps_assign)
          ps_reg <= 8'h00; // [RULE_05]
      end else if (tick_rise) begin
        if (!ps_assign) begin
          timer_reg <= timer_reg + 8'h01;
        end else if (ps_reg >= ps_top) begin
          ps_reg <= 8'h00;
          timer_reg <= timer_reg + 8'h01;
        end else begin
          ps_reg <= ps_reg + 8'h01;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // core state and flags
  // ------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (wr_f && fld_f != `LCD_F_PORT && fld_f != `LCD_F_TIMER)
      mem_reg[mem_addr] <= res; // [RULE_07]
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_o <= 8'h00;
      port_o <= 8'h00;
      stat_reg <= `LCD_STAT_RST;
      squash_reg <= 1'b0;
      standby_o <= 1'b0;
      pc_change_o <= 1'b0;
      nop_cycle_o <= 1'b0;
      ctrl_reg <= `LCD_CTRL_RST;
    end else begin
      standby_o <= sleep_op;
      pc_change_o <= pc_chg;
      nop_cycle_o <= instr_valid_i & squash_reg;
      // second cycle of a branch or taken skip runs as a no-operation
      if (instr_valid_i)
        squash_reg <= ~squash_reg & (pc_chg | skip); // [RULE_06]
      if (wr_f && fld_f == `LCD_F_PORT)
        port_o <= res;
      if (bus_wr_reg && bus_addr_reg == `LCD_OFS_CTRL)
        ctrl_reg <= hwdata[4:0];
      // core write wins over a bus write in the same cycle
      if (wr_w)
        acc_o <= res; // [RULE_09]
      else if (bus_wr_reg && bus_addr_reg == `LCD_OFS_WREG)
        acc_o <= hwdata[7:0];
      if (z_we)
        stat_reg[`LCD_ST_Z] <= lcd_zero(res); // [RULE_02] [RULE_03]
      if (cdc_we) begin
        stat_reg[`LCD_ST_C] <= ~sub_full[8]; // [RULE_02]
        stat_reg[`LCD_ST_HALF_CARRY] <= ~sub_low[4]; // [RULE_02]
      end
      if (sleep_op) begin
        stat_reg[`LCD_ST_TIMEOUT] <= 1'b1; // [RULE_01]
        stat_reg[`LCD_ST_POWERDOWN] <= 1'b0; // [RULE_01]
      end
    end
  end

  // ------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ------------------------------------------------------------
  wire bus_go = hsel & htrans[1] & hready;
  reg [31:0] rd_val;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @* begin
    case (haddr[7:0])
      `LCD_OFS_CTRL: rd_val = {27'h0, ctrl_reg};
      `LCD_OFS_WREG: rd_val = {24'h0, acc_o};
      `LCD_OFS_STAT: rd_val = {27'h0, stat_reg};
      `LCD_OFS_TIMER: rd_val = {24'h0, timer_reg};
      `LCD_OFS_PORT: rd_val = {24'h0, port_o};
      `LCD_OFS_PINS: rd_val = {24'h0, pins_reg};
      default: rd_val = 32'h0;
    endcase
    if (|haddr[31:8])
      rd_val = 32'h0;
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_wr_reg <= 1'b0;
      bus_addr_reg <= 8'h00;
      hrdata <= 32'h0;
    end else begin
      if (hready) begin
        bus_wr_reg <= bus_go & hwrite & ~|haddr[31:8];
        bus_addr_reg <= haddr[7:0];
      end
      if (bus_go & ~hwrite)
        hrdata <= rd_val;
    end
  end
endmodule

// ---- tb/lcd_core_checker.sv ----
`timescale 1ns/1ps
module lcd_core_checker (
  // clock and reset
  input wire clk_sys_i,
  input wire rst_n_i,
  // watched ports
  input wire instr_valid_i,
  input wire [13:0] instr_i,
  input wire [7:0] port_pins_i,
  input wire [7:0] port_o,
  input wire standby_o,
  input wire pc_change_o,
  input wire nop_cycle_o,
  input wire [7:0] acc_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // redirect pending and a new word offered: that word must die
  sequence s_redirect;
    pc_change_o && instr_valid_i;
  endsequence
  a_standby_pulse: assert property (instr_valid_i && instr_i == 14'h0063
    |=> standby_o || nop_cycle_o) else $error("standby pulse missing");
  a_standby_cause: assert property (standby_o
    |-> $past(instr_valid_i && instr_i == 14'h0063)) else $error("stray standby");
  a_minus_acc: assert property (instr_valid_i && instr_i[13:9] == 5'h1e
    |=> nop_cycle_o || acc_o == $past(instr_i[7:0] - acc_o)) else $error("bad subtract");
  a_xor_acc: assert property (instr_valid_i && instr_i[13:8] == 6'h3a
    |=> nop_cycle_o || acc_o == $past(instr_i[7:0] ^ acc_o)) else $error("bad xor");
  a_pin_writeback: assert property (instr_valid_i && instr_i == 14'h0885
    |=> nop_cycle_o || port_o == $past(port_pins_i, 3)) else $error("latch used");
  a_jump_redirect: assert property (instr_valid_i && instr_i[13:12] == 2'h2
    |=> pc_change_o || nop_cycle_o) else $error("jump without redirect");
  a_squash_next: assert property (s_redirect |=> nop_cycle_o)
    else $error("no squash cycle");
  a_squash_quiet: assert property (s_redirect |=> !pc_change_o && !standby_o)
    else $error("squashed word acted");
  a_nop_cause: assert property (nop_cycle_o |-> $past(instr_valid_i))
    else $error("squash without word");
endmodule
bind lcd_core lcd_core_checker lcd_core_checker_inst (.clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
  .port_pins_i(port_pins_i), .port_o(port_o), .standby_o(standby_o),
  .pc_change_o(pc_change_o), .nop_cycle_o(nop_cycle_o), .acc_o(acc_o));

// ---- tb/tb_lcd_core.sv ----
`timescale 1ns/1ps
module tb_lcd_core;
  typedef struct packed {int c; int k; logic [7:0] v;} lcd_note_t;
  reg clk_sys_i = 0, rst_n_i = 0, instr_valid_i = 0, timer_tick_i = 0;
  reg [13:0] instr_i = 0;
  reg [7:0] port_pins_i = 0;
  reg hsel = 0, hwrite = 0;
  reg [31:0] haddr = 0, hwdata = 0;
  reg [1:0] htrans = 0;
  reg [2:0] hsize = 0;
  wire hready, hreadyout, hresp, standby_o, pc_change_o, nop_cycle_o;
  wire [7:0] port_o, acc_o;
  wire [31:0] hrdata;
  int failures = 0, compares = 0, cyc = 0, i, j;
  logic [7:0] a, k, r8;
  logic [31:0] rd;
  lcd_note_t q[$];
  assign hready = hreadyout;
  always #5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) cyc <= cyc + 1;
  lcd_core lcd_core_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .instr_valid_i(instr_valid_i), .instr_i(instr_i), .port_pins_i(port_pins_i),
    .timer_tick_i(timer_tick_i), .port_o(port_o), .standby_o(standby_o),
    .pc_change_o(pc_change_o), .nop_cycle_o(nop_cycle_o), .acc_o(acc_o), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // result shows at the executing edge, one edge after the edge that issues the word
  task note(input int kind, input logic [7:0] v);
    q.push_back('{cyc + 2, kind, v});
  endtask
  task exec(input logic [13:0] w);
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b1;
    instr_i <= w;
  endtask
  task idle;
    @(posedge clk_sys_i);
    instr_valid_i <= 1'b0;
  endtask
  // one tick pulse per pass, left time to cross the synchroniser
  task tick(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      timer_tick_i <= 1'b1;
      @(posedge clk_sys_i);
      timer_tick_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
    end
  endtask
  task ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task rdchk(input logic [7:0] ad, input logic [31:0] e);
    ahb(1'b0, ad, 32'h0);
    check(rd, e);
  endtask
  task conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(negedge clk_sys_i) begin
    for (j = q.size() - 1; j >= 0; j--) begin
      if (q[j].c == cyc) begin
        case (q[j].k)
          0: check(acc_o, q[j].v);
          1: check(port_o, q[j].v);
          2: check(standby_o, q[j].v);
          3: check(pc_change_o, q[j].v);
          default: check(nop_cycle_o, q[j].v);
        endcase
        q.delete(j);
      end
    end
  end
  initial begin
    #100000;
    failures++;
    conclude;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(60805));
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rdchk(8'h08, 32'h18);
    for (i = 0; i < 8; i++) begin
      a = $urandom;
      k = $urandom;
      r8 = $urandom;
      ahb(1'b1, 8'h04, {24'h0, a});
      exec({6'h3a, k});
      note(0, a ^ k);
      exec({5'h1e, r8[0], r8});
      note(0, r8 - (a ^ k));
      idle;
    end
    $display("test literal ops done");
    ahb(1'b1, 8'h04, 32'h3);
    exec(14'h3c05);
    note(0, 8'h02);
    exec(14'h3a02);
    note(0, 8'h00);
    idle;
    rdchk(8'h08, 32'h1f);
    exec(14'h0063);
    note(2, 8'h01);
    idle;
    rdchk(8'h08, 32'h17);
    $display("test flags done");
    exec(14'h2800);
    note(3, 8'h01);
    exec(14'h3aff);
    note(4, 8'h01);
    note(0, 8'h00);
    exec(14'h3a0f);
    note(0, 8'h0f);
    idle;
    $display("test redirect done");
    port_pins_i <= 8'h5a;
    repeat (4) idle;
    exec(14'h0885);
    note(1, 8'h5a);
    idle;
    rdchk(8'h10, 32'h5a);
    ahb(1'b1, 8'h00, 32'h1);
    exec(14'h0081);
    idle;
    rdchk(8'h0c, 32'h0f);
    ahb(1'b1, 8'h00, 32'h3);
    tick(2);
    exec(14'h0081);
    idle;
    tick(3);
    rdchk(8'h0c, 32'h0f);
    tick(1);
    rdchk(8'h0c, 32'h10);
    rdchk(8'h20, 32'h0);
    $display("test port timer done");
    ahb(1'b1, 8'h04, 32'h11);
    exec(14'h00a0);
    idle;
    ahb(1'b1, 8'h00, 32'h10);
    ahb(1'b1, 8'h04, 32'h22);
    exec(14'h00a0);
    exec(14'h0820);
    note(0, 8'h22);
    idle;
    ahb(1'b1, 8'h00, 32'h0);
    exec(14'h0820);
    note(0, 8'h11);
    idle;
    ahb(1'b1, 8'h04, 32'h1);
    exec(14'h00a1);
    exec(14'h0ba1);
    exec(14'h3aff);
    note(4, 8'h01);
    note(0, 8'h01);
    exec(14'h3aff);
    note(0, 8'hfe);
    idle;
    $display("test bank skip done");
    repeat (3) idle;
    conclude;
  end
endmodule
